// ### src/amc_pkg.sv
// package for the measurement converter control block: register map,
// field layouts, channel and scan codes, fsm states, timing helpers.
// assumes a 20 MHz pclk and a 12-bit converter front end outside the block.
package amc_pkg;

    // ************************************************************
    // register map (byte addresses on the apb bus)
    // ************************************************************
    localparam logic [7:0] AMC_OFF_CTRL = 8'h00;
    localparam logic [7:0] AMC_OFF_SEL = 8'h04;
    localparam logic [7:0] AMC_OFF_STAT = 8'h08;
    localparam logic [7:0] AMC_OFF_RES_BASE = 8'h10;
    localparam logic [7:0] AMC_OFF_RES_LAST = 8'h20;
    localparam logic [15:0] AMC_CTRL_RST = 16'h0000;
    localparam logic [3:0] AMC_SEL_RST = 4'h0;

    // status register bit positions
    localparam int AMC_STAT_BUSY = 0;
    localparam int AMC_STAT_PD = 1;
    localparam int AMC_STAT_NEW_LSB = 2;

    // ************************************************************
    // channels and scan codes
    // ************************************************************
    localparam int AMC_NCHAN = 5;
    localparam logic [2:0] AMC_CH_SUPPLY = 3'h0;
    localparam logic [2:0] AMC_CH_AUXILIARY_INPUT_ONE = 3'h1;
    localparam logic [2:0] AMC_CH_AUXILIARY_INPUT_TWO = 3'h2;
    localparam logic [2:0] AMC_CH_THERM1 = 3'h3;
    localparam logic [2:0] AMC_CH_THERM2 = 3'h4;
    localparam logic [2:0] AMC_CH_NONE = 3'h7;

    localparam logic [3:0] AMC_SCAN_NONE = 4'h0;
    localparam logic [3:0] AMC_SCAN_SUPPLY = 4'h6;
    localparam logic [3:0] AMC_SCAN_AUXILIARY_INPUT_TWO = 4'h7;
    localparam logic [3:0] AMC_SCAN_AUXILIARY_INPUT_ONE = 4'h8;
    localparam logic [3:0] AMC_SCAN_AUTO = 4'h9;
    localparam logic [3:0] AMC_SCAN_THERM1 = 4'hA;
    localparam logic [3:0] AMC_SCAN_PORT = 4'hB;
    localparam logic [3:0] AMC_SCAN_THERM2 = 4'hC;

    // ************************************************************
    // types
    // ************************************************************
    typedef struct packed {
        logic rsvd15;
        logic halt;
        logic [3:0] scan;
        logic [1:0] width;
        logic [1:0] count;
        logic [1:0] rate;
        logic [2:0] rsvd;
        logic median;
    } amc_ctrl_t;

    typedef struct packed {
        logic start;
        logic power_down;
        logic [2:0] chan;
        logic [1:0] width;
        logic [1:0] rate;
    } amc_conv_req_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_CONV, ST_MED_CAND, ST_MED_CLAT, ST_MED_RD, ST_MED_CMP, ST_STORE
    } amc_state_t;

    // ************************************************************
    // timing and decoding helpers
    // ************************************************************
    localparam int AMC_PCLK_NS = 50;
    localparam int AMC_CONV_EXTRA = 4;
    localparam int AMC_NS_PER_US = 1000;
    localparam int AMC_SMP_BITS = 12;

    function automatic int amc_res_bits(logic [1:0] code);
        case (code)
            2'h1: return 8;
            2'h2: return 10;
            default: return 12;
        endcase
    endfunction

    function automatic int amc_rate_mhz(logic [1:0] code);
        case (code)
            2'h0: return 8;
            2'h1: return 4;
            2'h2: return 2;
            default: return 1;
        endcase
    endfunction

    // (bits + 4) internal clock periods, rounded up to whole pclk cycles
    function automatic logic [8:0] amc_conv_cycles(logic [1:0] width, logic [1:0] rate);
        int num;
        int den;
        num = (amc_res_bits(width) + AMC_CONV_EXTRA) * AMC_NS_PER_US;
        den = amc_rate_mhz(rate) * AMC_PCLK_NS;
        return 9'((num + den - 1) / den);
    endfunction

    function automatic logic [4:0] amc_avg_samples(logic [1:0] count, logic median);
        case (count)
            2'h1: return median ? 5'd5 : 5'd4;
            2'h2: return median ? 5'd9 : 5'd8;
            2'h3: return median ? 5'd15 : 5'd16;
            default: return 5'd1;
        endcase
    endfunction

    function automatic logic [2:0] amc_mean_shift(logic [1:0] count);
        case (count)
            2'h1: return 3'd2;
            2'h2: return 3'd3;
            2'h3: return 3'd4;
            default: return 3'd0;
        endcase
    endfunction

    // channel mask for a scan code; select bits are auxiliary_input_one, auxiliary_input_two, therm1, therm2
    function automatic logic [4:0] amc_scan_mask(logic [3:0] scan, logic [3:0] sel);
        case (scan)
            AMC_SCAN_SUPPLY: return 5'h01;
            AMC_SCAN_AUXILIARY_INPUT_ONE: return 5'h02;
            AMC_SCAN_AUXILIARY_INPUT_TWO: return 5'h04;
            AMC_SCAN_THERM1: return 5'h08;
            AMC_SCAN_THERM2: return 5'h10;
            AMC_SCAN_PORT: return 5'h07;
            AMC_SCAN_AUTO: return {sel, 1'b0};
            default: return 5'h00;
        endcase
    endfunction

endpackage

// ### src/amc_sample_mem.sv
// sample store for median filtering: one write port, one read port.
// read data come from a register one cycle after the address.
`timescale 1ns/1ps
module amc_sample_mem
    import amc_pkg::*;
(
    input wire logic pclk,
    input wire logic we,
    input wire logic [3:0] waddr,
    input wire logic [11:0] wdata,
    input wire logic [3:0] raddr,
    output logic [11:0] rdata_ff
);

    // ************************************************************
    // storage
    // ************************************************************
    logic [11:0] mem [16];

    // no reset: contents are always written before they are read
    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_ff <= mem[raddr];
    end

endmodule

// ### src/amc_ctrl.sv
// measurement converter control: apb registers, scan sequencing,
// conversion timing, mean and median averaging, result registers.
// assumes a converter front end that holds conv_data valid by the last
// cycle of each conversion window it is started for.
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps

module amc_ctrl
    import amc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output amc_conv_req_t conv_req,
    input wire logic [11:0] conv_data
);

    // ************************************************************
    // declarations
    // ************************************************************
    amc_ctrl_t ctrl_ff;
    amc_ctrl_t wr_val;
    amc_ctrl_t rd_ctrl;
    amc_state_t state_ff, nxt_state;
    logic [3:0] sel_ff;
    logic [4:0] mask_ff, nxt_mask;
    logic wrap_ff, nxt_wrap;
    logic [2:0] chan_ff, nxt_chan;
    logic [8:0] cyc_ff, nxt_cyc;
    logic [4:0] smp_ff, nxt_smp;
    logic [15:0] sum_ff, nxt_sum;
    logic [3:0] cand_i_ff, nxt_cand_i;
    logic [3:0] j_ff, nxt_j;
    logic [4:0] less_ff, nxt_less;
    logic [4:0] leq_ff, nxt_leq;
    logic [11:0] cand_ff, nxt_cand;
    logic [11:0] result_ff, nxt_result;
    logic start_ff, nxt_start;
    logic pd_ff, nxt_pd;
    logic [31:0] prdata_ff;
    logic [11:0] res_ff [AMC_NCHAN];
    logic [4:0] new_ff;
    logic apb_setup, apb_access, hit_ctrl, hit_sel, hit_stat, mapped;
    logic wr_ok, wr_ctrl, rd_done, busy, store, last_cyc;
    logic [2:0] res_sel, first_chan, next_in_seq;
    logic [8:0] conv_len;
    logic [4:0] nsmp, less_n, leq_n, med_k;
    logic [2:0] shift;
    logic [11:0] sample, mem_rdata;
    logic [15:0] sum_plus;
    logic [3:0] mem_raddr;
    logic mem_we;
    logic [31:0] rd_mux;

    // ************************************************************
    // decoding functions
    // ************************************************************
    // result register index for an address, none when not a result word
    function automatic logic [2:0] res_index(logic [7:0] addr);
        logic [7:0] off;
        off = addr - AMC_OFF_RES_BASE;
        if (addr < AMC_OFF_RES_BASE || addr > AMC_OFF_RES_LAST || addr[1:0] != 2'h0) begin
            return AMC_CH_NONE;
        end
        return off[4:2];
    endfunction

    // lowest masked channel above cur; wraps to the lowest when asked
    function automatic logic [2:0] next_chan(logic [4:0] m, logic [2:0] cur, logic wrap);
        logic [2:0] r;
        r = AMC_CH_NONE;
        for (int k = AMC_NCHAN - 1; k >= 0; k--) begin
            if (m[k] && 3'(k) > cur && cur != AMC_CH_NONE) begin
                r = 3'(k);
            end
        end
        if (r == AMC_CH_NONE && wrap) begin
            for (int k = AMC_NCHAN - 1; k >= 0; k--) begin
                if (m[k]) begin
                    r = 3'(k);
                end
            end
        end
        return r;
    endfunction

    // ************************************************************
    // apb slave: zero wait states, error on unmapped words
    // ************************************************************
    assign apb_setup = psel && !penable;
    assign apb_access = psel && penable;
    assign hit_ctrl = paddr == AMC_OFF_CTRL;
    assign hit_sel = paddr == AMC_OFF_SEL;
    assign hit_stat = paddr == AMC_OFF_STAT;
    assign res_sel = res_index(paddr);
    assign mapped = hit_ctrl || hit_sel || hit_stat || res_sel != AMC_CH_NONE;
    assign pready = 1'b1;
    assign pslverr = apb_access && !mapped;
    assign wr_ok = apb_access && pwrite && mapped;
    assign wr_ctrl = wr_ok && hit_ctrl;
    assign rd_done = apb_access && !pwrite && res_sel != AMC_CH_NONE;
    assign wr_val = amc_ctrl_t'(pwdata[15:0]);
    assign prdata = prdata_ff;

    // halt bit reads back as "not busy"; rate reads as written
    always_comb begin
        rd_ctrl = ctrl_ff;
        rd_ctrl.halt = !busy;
    end

    // read mux; result words are zero above bit eleven
    assign rd_mux = hit_ctrl ? {16'h0000, rd_ctrl} :
        hit_sel ? {28'h0000000, sel_ff} :
        hit_stat ? {25'h0000000, new_ff, pd_ff, busy} :
        res_sel != AMC_CH_NONE ? {20'h00000, res_ff[res_sel]} :
        32'h00000000;

    // read data captured in the setup cycle so it is a flop by the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
        end else if (apb_setup && !pwrite) begin
            prdata_ff <= rd_mux;
        end
    end

    // control and select registers; reserved bits are never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= amc_ctrl_t'(AMC_CTRL_RST);
            sel_ff <= AMC_SEL_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= {2'b00, wr_val.scan, wr_val.width, wr_val.count, wr_val.rate, 3'b000, wr_val.median};
            end
            if (wr_ok && hit_sel) begin
                sel_ff <= pwdata[3:0];
            end
        end
    end

    // ************************************************************
    // conversion datapath
    // ************************************************************
    // settings only change on a control write, which restarts the sequence
    assign conv_len = amc_conv_cycles(ctrl_ff.width, ctrl_ff.rate);
    assign nsmp = amc_avg_samples(ctrl_ff.count, ctrl_ff.median);
    assign shift = amc_mean_shift(ctrl_ff.count);
    assign med_k = (nsmp - 5'd1) >> 1;
    // converter delivers a 12-bit code; keep its top bits, right-justified
    assign sample = conv_data >> (AMC_SMP_BITS - amc_res_bits(ctrl_ff.width));
    assign sum_plus = sum_ff + {4'h0, sample};
    assign last_cyc = cyc_ff == conv_len - 9'd1;
    assign mem_we = state_ff == ST_CONV && last_cyc;
    assign mem_raddr = state_ff == ST_MED_CAND ? cand_i_ff : j_ff;
    assign less_n = less_ff + {4'h0, mem_rdata < cand_ff};
    assign leq_n = leq_ff + {4'h0, mem_rdata <= cand_ff};
    assign busy = state_ff != ST_IDLE;
    assign store = state_ff == ST_STORE;
    assign first_chan = next_chan(amc_scan_mask(wr_val.scan, sel_ff), AMC_CH_NONE, 1'b1);
    assign next_in_seq = next_chan(mask_ff, chan_ff, wrap_ff);

    amc_sample_mem u_mem (
        .pclk(pclk),
        .we(mem_we),
        .waddr(smp_ff[3:0]),
        .wdata(sample),
        .raddr(mem_raddr),
        .rdata_ff(mem_rdata)
    );

    // ************************************************************
    // sequencer
    // ************************************************************
    // median search is a rank count per candidate: slow but needs no sorter
    always_comb begin
        nxt_state = state_ff;
        nxt_mask = mask_ff;
        nxt_wrap = wrap_ff;
        nxt_chan = chan_ff;
        nxt_cyc = cyc_ff;
        nxt_smp = smp_ff;
        nxt_sum = sum_ff;
        nxt_cand_i = cand_i_ff;
        nxt_j = j_ff;
        nxt_less = less_ff;
        nxt_leq = leq_ff;
        nxt_cand = cand_ff;
        nxt_result = result_ff;
        nxt_start = 1'b0;
        nxt_pd = pd_ff;
        case (state_ff)
            ST_IDLE: begin
                nxt_state = ST_IDLE;
            end
            ST_CONV: begin
                if (last_cyc) begin
                    nxt_sum = sum_plus;
                    nxt_smp = smp_ff + 5'd1;
                    if (smp_ff + 5'd1 != nsmp) begin
                        nxt_cyc = 9'd0;
                        nxt_start = 1'b1;
                    end else if (ctrl_ff.median && nsmp != 5'd1) begin
                        nxt_state = ST_MED_CAND;
                        nxt_cand_i = 4'h0;
                        nxt_less = 5'd0;
                        nxt_leq = 5'd0;
                    end else begin
                        nxt_result = 12'(sum_plus >> shift);
                        nxt_state = ST_STORE;
                    end
                end else begin
                    nxt_cyc = cyc_ff + 9'd1;
                end
            end
            ST_MED_CAND: begin
                nxt_state = ST_MED_CLAT;
            end
            ST_MED_CLAT: begin
                nxt_cand = mem_rdata;
                nxt_j = 4'h0;
                nxt_state = ST_MED_RD;
            end
            ST_MED_RD: begin
                nxt_state = ST_MED_CMP;
            end
            ST_MED_CMP: begin
                nxt_less = less_n;
                nxt_leq = leq_n;
                nxt_state = ST_MED_RD;
                nxt_j = j_ff + 4'h1;
                if ({1'b0, j_ff} == nsmp - 5'd1) begin
                    if (less_n <= med_k && leq_n > med_k) begin
                        nxt_result = cand_ff;
                        nxt_state = ST_STORE;
                    end else begin
                        nxt_cand_i = cand_i_ff + 4'h1;
                        nxt_less = 5'd0;
                        nxt_leq = 5'd0;
                        nxt_state = ST_MED_CAND;
                    end
                end
            end
            ST_STORE: begin
                // auto scan wraps forever, the other modes end after the last
                if (next_in_seq == AMC_CH_NONE) begin
                    nxt_state = ST_IDLE;
                end else begin
                    nxt_chan = next_in_seq;
                    nxt_state = ST_CONV;
                    nxt_cyc = 9'd0;
                    nxt_smp = 5'd0;
                    nxt_sum = 16'h0000;
                    nxt_start = 1'b1;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        // a control write overrides whatever is running
        if (wr_ctrl) begin
            // a halt or an idle code must not leave a pending start behind
            nxt_start = 1'b0;
            nxt_cyc = 9'd0;
            nxt_smp = 5'd0;
            nxt_sum = 16'h0000;
            if (wr_val.halt) begin
                nxt_state = ST_IDLE;
                nxt_pd = 1'b1;
            end else begin
                nxt_pd = 1'b0;
                nxt_mask = amc_scan_mask(wr_val.scan, sel_ff);
                nxt_wrap = wr_val.scan == AMC_SCAN_AUTO;
                if (first_chan == AMC_CH_NONE) begin
                    nxt_state = ST_IDLE;
                end else begin
                    nxt_chan = first_chan;
                    nxt_state = ST_CONV;
                    nxt_start = 1'b1;
                end
            end
        end
    end

    // sequencer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff <= ST_IDLE;
            mask_ff <= 5'h00;
            wrap_ff <= 1'b0;
            chan_ff <= AMC_CH_SUPPLY;
            cyc_ff <= 9'd0;
            smp_ff <= 5'd0;
            sum_ff <= 16'h0000;
            cand_i_ff <= 4'h0;
            j_ff <= 4'h0;
            less_ff <= 5'd0;
            leq_ff <= 5'd0;
            cand_ff <= 12'h000;
            result_ff <= 12'h000;
            start_ff <= 1'b0;
            pd_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            mask_ff <= nxt_mask;
            wrap_ff <= nxt_wrap;
            chan_ff <= nxt_chan;
            cyc_ff <= nxt_cyc;
            smp_ff <= nxt_smp;
            sum_ff <= nxt_sum;
            cand_i_ff <= nxt_cand_i;
            j_ff <= nxt_j;
            less_ff <= nxt_less;
            leq_ff <= nxt_leq;
            cand_ff <= nxt_cand;
            result_ff <= nxt_result;
            start_ff <= nxt_start;
            pd_ff <= nxt_pd;
        end
    end

    // ************************************************************
    // result registers and new-data flags
    // ************************************************************
    // a store in the same cycle as a read keeps the flag set
    for (genvar g = 0; g < AMC_NCHAN; g++) begin : g_res
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                res_ff[g] <= 12'h000;
                new_ff[g] <= 1'b0;
            end else begin
                if (store && chan_ff == 3'(g)) begin
                    res_ff[g] <= result_ff;
                end
                new_ff[g] <= (store && chan_ff == 3'(g)) || (new_ff[g] && !(rd_done && res_sel == 3'(g)));
            end
        end
    end

    // converter request comes straight from flops
    assign conv_req = '{start: start_ff, power_down: pd_ff, chan: chan_ff, width: ctrl_ff.width, rate: ctrl_ff.rate};

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_ctrl_wr(logic [3:0] code);
        wr_ctrl && !wr_val.halt && wr_val.scan == code;
    endsequence

    a_halt_powers_down: assert property (wr_ctrl && wr_val.halt |=> !busy && pd_ff && !start_ff)
        else $error("halt write did not stop and power down");
    a_noscan_stays_idle: assert property (s_ctrl_wr(AMC_SCAN_NONE) |=> !busy[*3])
        else $error("no-scan code started a conversion");
    a_reserved_no_start: assert property (wr_ctrl && !wr_val.halt && amc_scan_mask(wr_val.scan, 4'hF) == 5'h00
        |=> !busy && !start_ff)
        else $error("reserved code started a conversion");
    a_single_starts: assert property (s_ctrl_wr(AMC_SCAN_THERM1) |=> start_ff && chan_ff == AMC_CH_THERM1)
        else $error("single code did not start on its input");
    a_conv_length: assert property (start_ff && !wr_ctrl |-> (cyc_ff == 9'd0 && state_ff == ST_CONV))
        else $error("conversion window did not begin at zero");
    a_rate_readback: assert property (wr_ctrl |=> ctrl_ff.rate == $past(pwdata[5:4]))
        else $error("rate field does not read back as written");
    a_port_inputs: assert property (store && !wrap_ff && mask_ff == 5'h07 |-> chan_ff <= AMC_CH_AUXILIARY_INPUT_TWO)
        else $error("port scan stored outside its three inputs");
    a_auto_wraps: assert property (store && wrap_ff && mask_ff != 5'h00 && !wr_ctrl |=> start_ff && busy)
        else $error("auto scan ended instead of repeating");
    a_result_width: assert property (store |-> result_ff < (12'h001 << amc_res_bits(ctrl_ff.width))
        || ctrl_ff.width[0] == ctrl_ff.width[1])
        else $error("result wider than selected resolution");
    a_sample_count: assert property (state_ff == ST_CONV |-> smp_ff < nsmp)
        else $error("more samples taken than the average needs");

endmodule

// ### sim/amc_ctrl_tb_top.sv
// testbench for the measurement converter control block
// assumes amc_ctrl with a zero-wait apb slave; conv_data stands in for the front end
`timescale 1ns/1ps
module amc_ctrl_tb_top;
    import amc_pkg::*;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    amc_conv_req_t conv_req;
    logic [11:0] conv_data = 0;
    logic [31:0] q[$];
    logic [7:0] seen = 0;
    int bad_count = 0;
    int total_checks = 0;
    int nstart = 0;
    int gap = 0;
    int t0 = 0;
    int cyc = 0;
    logic [3:0] cd[5] = '{4'h6, 4'h8, 4'h7, 4'hA, 4'hC};
    logic [3:0] rs[9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'hD, 4'hE, 4'hF};

    amc_ctrl dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conv_req(conv_req), .conv_data(conv_data));

    initial forever #25 pclk = ~pclk;

    // ****************************************
    // bus tasks and checking
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks=%0d errors=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // one idle edge after release, so back-to-back calls never drive psel twice at once
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        xfer(0, a, 0);
    endtask

    // poll the status busy flag; the watchdog covers a hang
    task automatic idle();
        repeat (3000) begin
            xfer(0, 8'h08, 0);
            if (prdata[0] === 1'b0) break;
        end
    endtask

    // read data against queued notes; start pulses, their spacing and channels
    always @(posedge pclk) begin
        cyc++;
        if (psel && penable) chk({pready, pslverr},
            {1'b1, !(paddr inside {8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20})});
        if (psel && penable && pready && !pwrite && q.size() > 0) chk(prdata, q.pop_front());
        if (conv_req.start === 1'b1) begin
            nstart++;
            gap = cyc - t0;
            t0 = cyc;
            seen[conv_req.chan] = 1'b1;
        end
    end

    initial begin
        #(60000 * 50);
        bad_count++;
        summarize();
    end

    initial begin
        logic [15:0] c;
        int b, n, L;
        b = $urandom(32'hd505);
        repeat (10) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        rd(8'h00, 32'h4000);
        rd(8'h30, 32'h0);
        // single inputs; 8 MHz only with 8-bit width
        for (int i = 0; i < 5; i++) begin
            c = {2'b00, cd[i], 2'($urandom), 8'h00};
            c[5:4] = (c[9:8] == 2'h1) ? 2'h0 : 2'h2;
            b = (c[9:8] == 2'h1) ? 8 : (c[9:8] == 2'h2) ? 10 : 12;
            conv_data <= 12'($urandom);
            nstart = 0;
            seen = 0;
            xfer(1, 8'h00, c);
            idle();
            chk(nstart, 1);
            chk(seen, 8'h1 << i);
            chk({conv_req.width, conv_req.rate}, {c[9:8], c[5:4]});
            rd(8'h08, 32'h4 << i);
            rd(8'h10 + 8'(4 * i), conv_data >> (12 - b));
            rd(8'h00, c | 16'h4000);
        end
        // averaging: width, count and rate all follow k; constant input keeps the value
        for (int m = 0; m < 2; m++)
            for (int k = 1; k < 4; k++) begin
                c = {6'h06, 2'(k), 2'(k), 2'(k), 3'h0, 1'(m)};
                b = 6 + 2 * k;
                n = m ? ((k == 3) ? 15 : 4 * k + 1) : (4 << (k - 1));
                L = (b + 4) * 20 / (8 >> k);
                conv_data <= 12'($urandom);
                nstart = 0;
                xfer(1, 8'h00, c);
                idle();
                chk(nstart, n);
                chk(gap, L);
                rd(8'h10, conv_data >> (12 - b));
            end
        foreach (rs[j]) begin
            nstart = 0;
            xfer(1, 8'h00, {2'b00, rs[j], 10'h100});
            repeat (20) @(posedge pclk);
            chk(nstart, 0);
        end
        nstart = 0;
        seen = 0;
        xfer(1, 8'h00, 16'h2D00);
        idle();
        chk(nstart, 3);
        chk(seen, 8'h07);
        xfer(1, 8'h04, 32'h5);
        seen = 0;
        xfer(1, 8'h00, 16'h2500);
        repeat (400) @(posedge pclk);
        chk(seen, 8'h0A);
        chk(32'(nstart > 8), 1);
        xfer(1, 8'h00, 16'h4000);
        n = nstart;
        repeat (200) @(posedge pclk);
        chk(conv_req.power_down, 1);
        chk(nstart, n);
        rd(8'h08, 32'h3E);
        summarize();
    end
endmodule
